// ### bench/default_start_watchdog_tb_top.sv
`timescale 1ns/1ps
`define CHECK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module default_start_watchdog_tb_top;
    import wdt_pkg::*;

    logic              core_clk_i     = 1'b0;
    logic              rst_n_i        = 1'b0;
    logic [ADDR_W-1:0] bus_addr_i     = 32'h00000000;
    logic [DATA_W-1:0] bus_wdata_i    = 8'h00;
    logic              bus_wr_i       = 1'b0;
    logic              bus_rd_i       = 1'b0;
    logic              bus_byte_i     = 1'b1;
    logic              bus_bitop_i    = 1'b0;
    logic              standby_idle_i = 1'b0;
    logic              standby_stop_i = 1'b0;
    logic              subclk_tick;
    logic [DATA_W-1:0] bus_rdata_o;
    logic              rst_req;
    logic              nmi_req;
    logic              irq_o;
    logic [15:0]       nmi_count;
    int                errors      = 0;
    int                checks_done = 0;

    always #4 core_clk_i = ~core_clk_i;

    // short bases keep every interval within a few thousand cycles
    default_start_watchdog #(.MAIN_EXP_BASE(5'h04), .SUB_EXP_BASE(5'h02))
    default_start_watchdog_i (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bus_addr_i(bus_addr_i),
        .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
        .bus_byte_i(bus_byte_i), .bus_bitop_i(bus_bitop_i), .subclk_tick_i(subclk_tick),
        .standby_idle_i(standby_idle_i), .standby_stop_i(standby_stop_i),
        .bus_rdata_o(bus_rdata_o), .watchdog_reset_request_o(rst_req),
        .watchdog_nmi_request_o(nmi_req), .irq_o(irq_o));

    soft_side_model #(.TICK_DIV(4)) soft_side_model_i (
        .core_clk_i(core_clk_i), .watchdog_nmi_request_i(nmi_req),
        .subclk_tick_o(subclk_tick), .nmi_count_o(nmi_count));

    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [31:0] a, input logic [7:0] d,
                      input logic byt = 1'b1, input logic bit_op = 1'b0);
        @(posedge core_clk_i);
        bus_addr_i  <= a;
        bus_wdata_i <= d;
        bus_byte_i  <= byt;
        bus_bitop_i <= bit_op;
        bus_wr_i    <= 1'b1;
        @(posedge core_clk_i);
        bus_wr_i    <= 1'b0;
        bus_byte_i  <= 1'b1;
        bus_bitop_i <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        bus_addr_i <= a;
        bus_rd_i   <= 1'b1;
        @(posedge core_clk_i);
        bus_rd_i   <= 1'b0;
        #1;
        d = bus_rdata_o;
    endtask

    task automatic do_reset();
        @(posedge core_clk_i);
        rst_n_i        <= 1'b0;
        standby_idle_i <= 1'b0;
        standby_stop_i <= 1'b0;
        repeat (12) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
    endtask

    task automatic summarize();
        $display("errors=%0d checks=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // interval measurement: cycles from a key write to the nmi pulse
    // ----------------------------------------------------------------
    task automatic meas(input logic [7:0] mode, input int stby, input int want);
        int         n;
        int         lim;
        logic       hit;
        logic [7:0] d;
        n   = 0;
        hit = 1'b0;
        lim = (want == 0) ? 2100 : want + 4;
        do_reset();
        wr(OFF_MODE, mode);
        rd(OFF_MODE, d);
        `CHECK(d, mode)
        wr(OFF_KEY, KEY_VAL);
        while (n < lim && !hit) begin
            @(posedge core_clk_i);
            standby_idle_i <= (stby == 1 && n < 40);
            standby_stop_i <= (stby == 2 && n < 40);
            #1;
            n++;
            hit = (nmi_req === 1'b1);
        end
        if (want == 0) begin
            `CHECK(hit, 1'b0)
        end else begin
            `CHECK(hit && n >= want - 4, 1'b1)
            rd(OFF_STAT, d);
            `CHECK(d[ST_NAT], 1'b1)
        end
    endtask

    logic [7:0] tm [13] = '{8'h20, 8'h21, 8'h22, 8'h27, 8'h28, 8'h2A, 8'h2F,
                            8'h20, 8'h20, 8'h28, 8'h1F, 8'h00, 8'h30};
    int ts [13] = '{0, 0, 0, 0, 0, 0, 0, 1, 2, 1, 0, 0, 0};
    int te [13] = '{16, 32, 64, 2048, 16, 64, 2048, 56, 56, 16, 0, 0, 0};

    initial begin
        #240000;
        errors++;
        summarize();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        logic [7:0]  d;
        logic [15:0] c0;
        int          n;
        do_reset();
        rd(OFF_MODE, d);
        `CHECK(d, MODE_RST)
        rd(OFF_KEY, d);
        `CHECK(d, KEY_RST)
        @(posedge core_clk_i);
        #1;
        `CHECK(bus_rdata_o, RD_NONE)
        n = 0;
        while (n < 2100 && rst_req !== 1'b1) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        `CHECK(n >= 2025 && n <= 2060, 1'b1)
        for (int i = 0; i < 13; i++) begin
            meas(tm[i], ts[i], te[i]);
        end
        // illegal accesses, nmi action selected with the longest interval
        do_reset();
        wr(OFF_MASK, 8'h03);
        wr(OFF_MODE, 8'h20, 1'b0);
        rd(OFF_MODE, d);
        `CHECK(d, MODE_RST)
        wr(OFF_MODE, 8'h27);
        for (int k = 0; k < 3; k++) begin
            c0 = nmi_count;
            if (k == 0) wr(OFF_KEY, 8'h00);
            if (k == 1) wr(OFF_KEY, KEY_VAL, 1'b1, 1'b1);
            if (k == 2) wr(OFF_MODE, 8'h20);
            #1;
            `CHECK(nmi_req, 1'b1)
            `CHECK(irq_o, 1'b1)
            @(posedge core_clk_i);
            #1;
            `CHECK(nmi_req, 1'b0)
            `CHECK(nmi_count - c0, 16'h0001)
            rd(OFF_STAT, d);
            `CHECK(d & 8'h03, 8'h02)
            @(posedge core_clk_i);
            #1;
            `CHECK(irq_o, 1'b0)
            wr(OFF_KEY, KEY_VAL);
        end
        rd(OFF_MODE, d);
        `CHECK(d, 8'h27)
        wr(OFF_MASK, 8'h00);
        wr(OFF_KEY, 8'h11);
        #1;
        `CHECK(nmi_req, 1'b1)
        `CHECK(irq_o, 1'b0)
        wr(32'hFFFFF6E0, 8'hFF);
        rd(32'hFFFFF6E0, d);
        `CHECK(d, RD_NONE)
        rd(OFF_KEY, d);
        `CHECK(d, KEY_RST)
        `CHECK(rst_req, 1'b0)
        // forced overflow in the default reset action
        do_reset();
        wr(OFF_KEY, 8'h55);
        @(posedge core_clk_i);
        #1;
        `CHECK(rst_req, 1'b1)
        `CHECK(nmi_req, 1'b0)
        repeat (20) @(posedge core_clk_i);
        #1;
        `CHECK(rst_req, 1'b1)
        summarize();
    end
endmodule // default_start_watchdog_tb_top

// ### bench/soft_side_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far side: subclock source and interrupt sink
// ----------------------------------------------------------------
module soft_side_model #(
    parameter int TICK_DIV = 4
) (
    input  wire logic        core_clk_i,
    input  wire logic        watchdog_nmi_request_i,
    output logic             subclk_tick_o,
    output logic      [15:0] nmi_count_o
);
    int phase = 0;

    initial begin
        subclk_tick_o = 1'b0;
        nmi_count_o   = 16'h0000;
    end

    // the subclock runs free, also while the core sits in idle or stop
    always @(posedge core_clk_i) begin
        phase         <= (phase + 1) % TICK_DIV;
        subclk_tick_o <= (phase == 0);
        if (watchdog_nmi_request_i === 1'b1) begin
            nmi_count_o <= nmi_count_o + 16'h0001;
        end
    end
endmodule // soft_side_model

// ### verilog/default_start_watchdog.sv
`timescale 1ns/1ps
module default_start_watchdog
    import wdt_pkg::*;
#(
    parameter logic [EXP_W-1:0] MAIN_EXP_BASE = MAIN_EXP_DEF,
    parameter logic [EXP_W-1:0] SUB_EXP_BASE  = SUB_EXP_DEF
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic [ADDR_W-1:0] bus_addr_i,
    input  wire logic [DATA_W-1:0] bus_wdata_i,
    input  wire logic              bus_wr_i,
    input  wire logic              bus_rd_i,
    input  wire logic              bus_byte_i,
    input  wire logic              bus_bitop_i,
    input  wire logic              subclk_tick_i,
    input  wire logic              standby_idle_i,
    input  wire logic              standby_stop_i,
    output logic      [DATA_W-1:0] bus_rdata_o,
    output logic                   watchdog_reset_request_o,
    output logic                   watchdog_nmi_request_o,
    output logic                   irq_o
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [DATA_W-1:0] mode;
        logic              mode_done;
        logic [ST_W-1:0]   status;
        logic [ST_W-1:0]   mask;
        logic [DATA_W-1:0] rdata;
        logic              nmi;
        logic              rst_req;
        logic              irq;
    } wdt_state_t;

    wdt_state_t        s_reg;
    wdt_state_t        s_next;
    logic              rst_n;
    logic              hit_mode;
    logic              hit_key;
    logic              hit_stat;
    logic              hit_mask;
    logic              mode_wr;
    logic              mode_take;
    logic              mode_again;
    logic              key_wr;
    logic              key_ok;
    logic              key_bad;
    logic              forced;
    logic              nat_ovf;
    logic              ovf_evt;
    logic              run;
    logic              held;
    logic              step;
    logic              cnt_clear;
    logic [EXP_W-1:0]  cur_exp;
    logic [CNT_W-1:0]  count;
    logic [1:0]        action;

    wdt_reset_sync wdt_reset_sync_i (
        .core_clk_i   (core_clk_i),
        .rst_n_i      (rst_n_i),
        .rst_sync_n_o (rst_n)
    );

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    always_comb begin
        hit_mode = 1'b0;
        hit_key  = 1'b0;
        hit_stat = 1'b0;
        hit_mask = 1'b0;
        if (bus_addr_i == OFF_MODE) begin
            hit_mode = 1'b1;
        end else if (bus_addr_i == OFF_KEY) begin
            hit_key = 1'b1;
        end else if (bus_addr_i == OFF_STAT) begin
            hit_stat = 1'b1;
        end else if (bus_addr_i == OFF_MASK) begin
            hit_mask = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // access checks
    // ----------------------------------------------------------------
    // only byte-wide, non-bit writes count as a mode write
    assign mode_wr    = bus_wr_i && hit_mode && bus_byte_i && !bus_bitop_i;
    assign mode_take  = mode_wr && !s_reg.mode_done;
    assign mode_again = mode_wr && s_reg.mode_done;
    assign key_wr     = bus_wr_i && hit_key;
    assign key_ok     = key_wr && bus_byte_i && !bus_bitop_i
                        && (bus_wdata_i == KEY_VAL);
    // a wrong key or a bit access both trip the timer
    assign key_bad    = key_wr && !key_ok;
    assign forced     = mode_again || key_bad;

    // ----------------------------------------------------------------
    // count control
    // ----------------------------------------------------------------
    assign cur_exp   = period_exp(s_reg.mode[SEL_MSB:0], MAIN_EXP_BASE,
                                  SUB_EXP_BASE);
    assign run       = mode_runs(s_reg.mode);
    // main-clock counting freezes in idle/stop, halt has no effect
    assign held      = !s_reg.mode[SEL_SRC]
                       && (standby_idle_i || standby_stop_i);
    assign step      = run && !held
                       && (!s_reg.mode[SEL_SRC] || subclk_tick_i);
    // a new interval starts from zero rather than mid-count
    assign cnt_clear = key_ok || mode_take;

    wdt_tick_counter wdt_tick_counter_i (
        .core_clk_i   (core_clk_i),
        .rst_sync_n_i (rst_n),
        .clear_i      (cnt_clear),
        .step_i       (step),
        .exp_i        (cur_exp),
        .count_o      (count),
        .wrap_o       (nat_ovf)
    );

    assign ovf_evt = nat_ovf || forced;
    assign action  = s_reg.mode[ACT_HI:ACT_LO];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_next       = s_reg;
        s_next.rdata = RD_NONE;
        s_next.nmi   = 1'b0;
        if (mode_take) begin
            s_next.mode      = bus_wdata_i;
            s_next.mode_done = 1'b1;
        end
        if (bus_wr_i && hit_mask) begin
            s_next.mask = bus_wdata_i[ST_W-1:0];
        end
        // forced and natural overflow share the selected action
        if (ovf_evt) begin
            if (s_reg.mode[ACT_HI]) begin
                s_next.rst_req = 1'b1;
            end else if (s_reg.mode[ACT_LO]) begin
                s_next.nmi = 1'b1;
            end
        end
        // read clears, a new event in the same cycle still lands
        if (bus_rd_i && hit_stat) begin
            s_next.status = ST_NONE;
        end
        s_next.status[ST_NAT] = s_next.status[ST_NAT] | nat_ovf;
        s_next.status[ST_FRC] = s_next.status[ST_FRC] | forced;
        s_next.irq = |(s_next.status & s_next.mask);
        if (bus_rd_i) begin
            if (hit_mode) begin
                s_next.rdata = s_reg.mode;
            end else if (hit_key) begin
                s_next.rdata = KEY_RST;
            end else if (hit_stat) begin
                s_next.rdata = {6'h00, s_reg.status};
            end else if (hit_mask) begin
                s_next.rdata = {6'h00, s_reg.mask};
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_reg           <= '0;
            s_reg.mode      <= MODE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus_rdata_o              = s_reg.rdata;
    assign watchdog_reset_request_o = s_reg.rst_req;
    assign watchdog_nmi_request_o   = s_reg.nmi;
    assign irq_o                    = s_reg.irq;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_default_mode;
        @(posedge core_clk_i) disable iff (!rst_n)
        !s_reg.mode_done |-> s_reg.mode == MODE_RST;
    endproperty
    a_default_mode: assert property (p_default_mode)
        else $error("mode differs from reset value before first write");

    property p_autorun;
        @(posedge core_clk_i) disable iff (!rst_n)
        !s_reg.mode_done && !standby_idle_i && !standby_stop_i
        |-> step && !s_reg.mode[SEL_SRC];
    endproperty
    a_autorun: assert property (p_autorun)
        else $error("watchdog not counting on main clock after reset");

    property p_mode_lock;
        @(posedge core_clk_i) disable iff (!rst_n)
        s_reg.mode_done |=> $stable(s_reg.mode) && s_reg.mode_done;
    endproperty
    a_mode_lock: assert property (p_mode_lock)
        else $error("mode changed after its single write");

    property p_first_write;
        @(posedge core_clk_i) disable iff (!rst_n)
        mode_wr && !s_reg.mode_done
        |=> s_reg.mode == $past(bus_wdata_i) && count == CNT_ZERO;
    endproperty
    a_first_write: assert property (p_first_write)
        else $error("first mode write not taken");

    property p_second_write;
        @(posedge core_clk_i) disable iff (!rst_n)
        mode_wr && s_reg.mode_done && s_reg.mode[ACT_HI]
        |=> watchdog_reset_request_o;
    endproperty
    a_second_write: assert property (p_second_write)
        else $error("second mode write did not force overflow");

    property p_nmi_pulse;
        @(posedge core_clk_i) disable iff (!rst_n)
        ovf_evt && action == ACT_NMI
        |=> watchdog_nmi_request_o ##1 (!watchdog_nmi_request_o || $past(ovf_evt));
    endproperty
    a_nmi_pulse: assert property (p_nmi_pulse)
        else $error("nmi action did not pulse the nmi request");

    property p_stop_action;
        @(posedge core_clk_i) disable iff (!rst_n)
        action == ACT_STOP |=> !watchdog_nmi_request_o && !$rose(watchdog_reset_request_o);
    endproperty
    a_stop_action: assert property (p_stop_action)
        else $error("stopped watchdog raised a request");

    property p_interval;
        @(posedge core_clk_i) disable iff (!rst_n)
        nat_ovf |-> CNT_W'(count + CNT_ONE) == CNT_W'(CNT_ONE << cur_exp);
    endproperty
    a_interval: assert property (p_interval)
        else $error("overflow at wrong count");

    property p_stop_code;
        @(posedge core_clk_i) disable iff (!rst_n)
        s_reg.mode == MODE_OFF |-> !step && !nat_ovf;
    endproperty
    a_stop_code: assert property (p_stop_code)
        else $error("watchdog counts after 1FH");

    property p_key_clear;
        @(posedge core_clk_i) disable iff (!rst_n)
        key_ok |=> count == CNT_ZERO && !$rose(watchdog_reset_request_o);
    endproperty
    a_key_clear: assert property (p_key_clear)
        else $error("key write did not clear the counter");

    property p_bad_key;
        @(posedge core_clk_i) disable iff (!rst_n)
        key_wr && bus_wdata_i != KEY_VAL && s_reg.mode[ACT_HI]
        |=> watchdog_reset_request_o;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("wrong key did not force overflow");

    property p_bitop;
        @(posedge core_clk_i) disable iff (!rst_n)
        key_wr && bus_bitop_i && action == ACT_NMI
        |=> watchdog_nmi_request_o;
    endproperty
    a_bitop: assert property (p_bitop)
        else $error("bit access to key did not force overflow");

    property p_key_read;
        @(posedge core_clk_i) disable iff (!rst_n)
        bus_rd_i && hit_key |=> bus_rdata_o == KEY_RST;
    endproperty
    a_key_read: assert property (p_key_read)
        else $error("key register read wrong value");

    property p_reset_hold;
        @(posedge core_clk_i) disable iff (!rst_n)
        watchdog_reset_request_o |=> watchdog_reset_request_o [*3];
    endproperty
    a_reset_hold: assert property (p_reset_hold)
        else $error("reset request dropped");

    property p_main_standby;
        @(posedge core_clk_i) disable iff (!rst_n)
        held && !cnt_clear |=> $stable(count);
    endproperty
    a_main_standby: assert property (p_main_standby)
        else $error("main-clock count moved in idle or stop");

    property p_sub_standby;
        @(posedge core_clk_i) disable iff (!rst_n)
        run && s_reg.mode[SEL_SRC] && subclk_tick_i && !cnt_clear && !nat_ovf
        |=> count == CNT_W'($past(count) + CNT_ONE);
    endproperty
    a_sub_standby: assert property (p_sub_standby)
        else $error("subclock count did not advance");

    property p_status_keep;
        @(posedge core_clk_i) disable iff (!rst_n)
        forced |=> s_reg.status[ST_FRC] && irq_o == |(s_reg.status & s_reg.mask);
    endproperty
    a_status_keep: assert property (p_status_keep)
        else $error("forced event lost from status");

    property p_nat_nmi;
        @(posedge core_clk_i) disable iff (!rst_n)
        nat_ovf && action == ACT_NMI |=> watchdog_nmi_request_o;
    endproperty
    a_nat_nmi: assert property (p_nat_nmi)
        else $error("natural overflow gave no nmi request");

    property p_nat_reset;
        @(posedge core_clk_i) disable iff (!rst_n)
        nat_ovf && s_reg.mode[ACT_HI] |=> watchdog_reset_request_o;
    endproperty
    a_nat_reset: assert property (p_nat_reset)
        else $error("natural overflow gave no reset request");

    property p_sel_stop;
        @(posedge core_clk_i) disable iff (!rst_n)
        s_reg.mode[SEL_MSB] |-> !step && !nat_ovf;
    endproperty
    a_sel_stop: assert property (p_sel_stop)
        else $error("interval code with top bit set still counts");

    property p_rdata_idle;
        @(posedge core_clk_i) disable iff (!rst_n)
        !bus_rd_i |=> bus_rdata_o == RD_NONE;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data shown outside its read cycle");

    property p_status_clear;
        @(posedge core_clk_i) disable iff (!rst_n)
        bus_rd_i && hit_stat && !nat_ovf && !forced |=> s_reg.status == ST_NONE;
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("status read did not clear the events");

endmodule // default_start_watchdog

// ### verilog/wdt_pkg.sv
// Contract
// - self-starts counting in reset mode after release
// - mode register resets to 67H
// - mode register readable always, writable once only
// - second mode write forces an overflow
// - bits 6:5 pick stop, nmi or reset
// - interval field picks main or sub period
// - writing 1FH stops the watchdog
// - byte write of ACH clears the counter
// - any other key value forces an overflow
// - single-bit access to key forces overflow
// - key register always reads 9AH
// - elapsed interval raises reset or nmi request
// - main-clock source halts in idle and stop
// - counts in halt; subclock counts in standby
package wdt_pkg;

    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W  = 26;
    localparam int unsigned EXP_W  = 5;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_MODE = 32'hFFFFF6D0;
    localparam logic [ADDR_W-1:0] OFF_KEY  = 32'hFFFFF6D4;
    localparam logic [ADDR_W-1:0] OFF_STAT = 32'hFFFFF6D8;
    localparam logic [ADDR_W-1:0] OFF_MASK = 32'hFFFFF6DC;

    localparam logic [DATA_W-1:0] MODE_RST = 8'h67;
    localparam logic [DATA_W-1:0] MODE_OFF = 8'h1F;
    localparam logic [DATA_W-1:0] KEY_RST  = 8'h9A;
    localparam logic [DATA_W-1:0] KEY_VAL  = 8'hAC;
    localparam logic [DATA_W-1:0] RD_NONE  = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int unsigned ACT_HI  = 6;
    localparam int unsigned ACT_LO  = 5;
    localparam int unsigned SEL_MSB = 4;
    localparam int unsigned SEL_SRC = 3;
    localparam int unsigned ST_NAT  = 0;
    localparam int unsigned ST_FRC  = 1;
    localparam int unsigned ST_W    = 2;

    localparam logic [1:0] ACT_STOP = 2'h0;
    localparam logic [1:0] ACT_NMI  = 2'h1;
    localparam logic [1:0] ST_NONE  = 2'h0;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam logic [EXP_W-1:0] MAIN_EXP_DEF = 5'h12;
    localparam logic [EXP_W-1:0] SUB_EXP_DEF  = 5'h09;
    localparam logic [CNT_W-1:0] CNT_ONE      = 26'h0000001;
    localparam logic [CNT_W-1:0] CNT_ZERO     = 26'h0000000;

    // log2 of the overflow period for an interval code
    function automatic logic [EXP_W-1:0] period_exp(
        input logic [EXP_W-1:0] sel,
        input logic [EXP_W-1:0] main_base,
        input logic [EXP_W-1:0] sub_base
    );
        logic [EXP_W-1:0] step;
        step = {2'h0, sel[2:0]};
        return sel[SEL_SRC] ? EXP_W'(sub_base + step) : EXP_W'(main_base + step);
    endfunction

    // counter runs only with a live action and interval code
    function automatic logic mode_runs(input logic [DATA_W-1:0] mode);
        return !mode[SEL_MSB] && (mode[ACT_HI] || mode[ACT_LO]);
    endfunction

endpackage

// ### verilog/wdt_reset_sync.sv
`timescale 1ns/1ps
module wdt_reset_sync (
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    output logic      rst_sync_n_o
);
    logic [1:0] sync_reg;

    // ----------------------------------------------------------------
    // release through two flops, assert at once
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_reg <= 2'h0;
        end else begin
            sync_reg <= {sync_reg[0], 1'b1};
        end
    end

    assign rst_sync_n_o = sync_reg[1];

endmodule // wdt_reset_sync

// ### verilog/wdt_tick_counter.sv
`timescale 1ns/1ps
module wdt_tick_counter
    import wdt_pkg::*;
(
    input  wire logic             core_clk_i,
    input  wire logic             rst_sync_n_i,
    input  wire logic             clear_i,
    input  wire logic             step_i,
    input  wire logic [EXP_W-1:0] exp_i,
    output logic      [CNT_W-1:0] count_o,
    output logic                  wrap_o
);
    typedef struct packed {
        logic [CNT_W-1:0] count;
    } cnt_state_t;

    cnt_state_t cnt_reg;
    cnt_state_t cnt_next;
    logic [CNT_W-1:0] last_val;

    // ----------------------------------------------------------------
    // counter; a clear beats a step in the same cycle
    // ----------------------------------------------------------------
    always_comb begin
        cnt_next = cnt_reg;
        last_val = CNT_W'((CNT_ONE << exp_i) - CNT_ONE);
        wrap_o   = step_i && !clear_i && (cnt_reg.count == last_val);
        if (clear_i) begin
            cnt_next.count = CNT_ZERO;
        end else if (wrap_o) begin
            cnt_next.count = CNT_ZERO;
        end else if (step_i) begin
            cnt_next.count = CNT_W'(cnt_reg.count + CNT_ONE);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_sync_n_i) begin
        if (!rst_sync_n_i) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign count_o = cnt_reg.count;

endmodule // wdt_tick_counter
